// ===== inc/asc_pkg.sv
// constants, field layout and state types of the alarm and system control block
// assumes a 25 MHz core clock and a 16-bit framed serial port on its own clock
package asc_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned MS_NS          = 1_000_000;
  localparam int unsigned SOFT_RESET_MS  = 70;
  localparam int unsigned NV_UPDATE_MS   = 70;
  localparam int unsigned CAL_RESTORE_MS = 71;
  localparam int unsigned BIAS_CORR_MS   = 70;
  localparam int unsigned CHECKSUM_MS    = 21;
  localparam int unsigned DRDY_MIN_NS    = 100_000;
  localparam int unsigned DRDY_MAX_NS    = 200_000;
  localparam int unsigned DRDY_MIN_CYC   = (DRDY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DRDY_MAX_CYC   = DRDY_MAX_NS / CLK_PERIOD_NS;
  localparam logic [12:0] DRDY_CYC       = 13'((DRDY_MIN_CYC + DRDY_MAX_CYC) / 2);

  function automatic int unsigned ms_to_cyc(int unsigned ms);
    return ms * MS_NS / CLK_PERIOD_NS;
  endfunction

  // register byte addresses
  localparam logic [6:0] OFS_NVCNT  = 7'h00;
  localparam logic [6:0] OFS_THR1   = 7'h10;
  localparam logic [6:0] OFS_THR2   = 7'h12;
  localparam logic [6:0] OFS_WIN1   = 7'h14;
  localparam logic [6:0] OFS_WIN2   = 7'h16;
  localparam logic [6:0] OFS_ALMCFG = 7'h18;
  localparam logic [6:0] OFS_GPIO   = 7'h1a;
  localparam logic [6:0] OFS_MISC   = 7'h1c;
  localparam logic [6:0] OFS_SLEEP  = 7'h24;
  localparam logic [6:0] OFS_FLAGS  = 7'h26;
  localparam logic [6:0] OFS_CMD    = 7'h28;
  localparam logic [6:0] OFS_LOTA   = 7'h32;
  localparam logic [6:0] OFS_LOTB   = 7'h34;
  localparam logic [6:0] OFS_LOTC   = 7'h36;
  localparam logic [6:0] OFS_PART   = 7'h38;
  localparam logic [6:0] OFS_SERIAL = 7'h3a;

  // field positions
  localparam int unsigned ALM_SRC_LSB    = 8;
  localparam int unsigned ALM_ROC_LSB    = 6;
  localparam int unsigned ALM_SENSE_LSB  = 4;
  localparam int unsigned ALM_FILT_BIT   = 3;
  localparam int unsigned ALM_OUT_EN     = 2;
  localparam int unsigned ALM_OUT_POL    = 1;
  localparam int unsigned ALM_OUT_SEL    = 0;
  localparam int unsigned FLG_ALM_LSB    = 8;
  localparam int unsigned FLG_SUM_BIT    = 6;
  localparam int unsigned CMD_SOFT_RESET = 7;
  localparam int unsigned CMD_NV_UPDATE  = 3;
  localparam int unsigned CMD_CAL_RESTORE = 1;
  localparam int unsigned CMD_BIAS_CORR  = 0;
  localparam int unsigned MISC_CHECKSUM  = 11;
  localparam int unsigned MISC_DR_EN     = 2;
  localparam int unsigned MISC_DR_POL    = 1;
  localparam int unsigned MISC_DR_SEL    = 0;
  localparam int unsigned GPIO_DATA_LSB  = 8;

  // source codes and write masks
  localparam logic [3:0]  SRC_OFF    = 4'h0;
  localparam logic [3:0]  SRC_RATE   = 4'h1;
  localparam logic [3:0]  SRC_TEMP   = 4'h2;
  localparam logic [3:0]  SRC_FLAGS  = 4'h3;
  localparam logic [15:0] CMD_WMASK  = 16'h008b;
  localparam logic [15:0] MISC_WMASK = 16'h0887;
  localparam logic [15:0] GPIO_WMASK = 16'h0f0f;

  // values after reset
  localparam logic [15:0] MISC_RST = 16'h0006;

  typedef enum logic [3:0] {
    ACT_IDLE  = 4'b0001,
    ACT_RESET = 4'b0010,
    ACT_NVUPD = 4'b0100,
    ACT_CHECK = 4'b1000
  } asc_act_e;

  typedef struct packed {
    logic [3:0]  cnt;
    logic [14:0] sh;
    logic [15:0] word;
    logic        tgl;
  } asc_link_s;

  typedef struct packed {
    logic [2:0]       tgl_s;
    logic [1:0][3:0]  dio_s;
    logic [1:0][15:0] thr, win, nv_thr, nv_win;
    logic [15:0]      almcfg, gpio, misc, sleep, flags, cmd, nvcnt;
    logic [15:0]      nv_almcfg, nv_gpio, nv_misc, nv_sleep;
    logic [15:0]      tx_word;
    logic [1:0][16:0] snap;
    logic [1:0][7:0]  wcnt;
    logic [1:0]       active;
    asc_act_e         act;
    logic [20:0]      timer;
    logic [15:0]      act_mask;
    logic             sum_bad;
    logic [12:0]      drdy_cnt;
    logic [3:0]       dout, doe;
    logic             halt;
  } asc_core_s;

endpackage

// ===== rtl/asc_system_ctrl.sv
// alarm monitors, global commands, write counter, memory check and digital line muxing
// assumes sample data and strobe on clk; serial port in mode 3, 16-bit frames on sclk
`timescale 1ns/1ps

// What this block does
// - rate-of-change mode compares source change over the window against threshold
// - window uses low byte only; zero and one both mean one sample
// - alarm 2 active sets error flag bit 9, alarm 1 sets bit 8
// - source codes: 0 off, 1 coarse rate, 2 temperature, 3 error flags
// - config bits 7 and 6 pick rate-of-change or static level per alarm
// - config bits 5 and 4 pick above-threshold or below-threshold trigger
// - config bit 3 feeds filtered data, only for the rate source
// - config bits 2..0 enable indicator, set its level and pick its line
// - host writes one to a command bit; device clears it when finished
// - soft reset drops data, reloads registers from stored copy, takes 70 ms
// - update, calibration restore and bias correction commit to nonvolatile store
// - 16-bit counter counts every nonvolatile commit, readable by host
// - control bit 11 runs 21 ms checksum; flag bit 6 set on mismatch
// - four general digital lines
// - first two lines: data ready first, alarm second, general use last
// - data ready field resets to 110; 100 gives negative pulse on line one
// - data ready pulse lasts between 100 and 200 microseconds
// - reading error flags clears them; persisting conditions set again next sample
// - threshold uses the data format of the selected source
module asc_system_ctrl #(
  parameter int unsigned SOFT_RESET_CYC  = asc_pkg::ms_to_cyc(asc_pkg::SOFT_RESET_MS),
  parameter int unsigned NV_UPDATE_CYC   = asc_pkg::ms_to_cyc(asc_pkg::NV_UPDATE_MS),
  parameter int unsigned CAL_RESTORE_CYC = asc_pkg::ms_to_cyc(asc_pkg::CAL_RESTORE_MS),
  parameter int unsigned BIAS_CORR_CYC   = asc_pkg::ms_to_cyc(asc_pkg::BIAS_CORR_MS),
  parameter int unsigned CHECKSUM_CYC    = asc_pkg::ms_to_cyc(asc_pkg::CHECKSUM_MS),
  // identity values below are arbitrary
  parameter logic [15:0] PART_ID         = 16'h1234,
  parameter logic [15:0] LOT_A           = 16'h0001,
  parameter logic [15:0] LOT_B           = 16'h0002,
  parameter logic [15:0] LOT_C           = 16'h0003,
  parameter logic [15:0] SERIAL_NO       = 16'h0004
) (
  // core clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // serial port, link clock domain
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso,
  // sample stream
  input  wire logic        sample_strobe,
  input  wire logic [15:0] coarse_rate_output,
  input  wire logic [15:0] filtered_rate_output,
  input  wire logic [15:0] temperature_output,
  // program memory check
  input  wire logic [15:0] prog_sum,
  input  wire logic [15:0] factory_sum,
  // digital lines, one to four
  input  wire logic [3:0]  dio_in,
  output logic [3:0]       dio_out,
  output logic [3:0]       dio_oe,
  // data collection held off during soft reset
  output logic             collection_halt
);

  localparam logic [20:0] SR_T  = 21'(SOFT_RESET_CYC);
  localparam logic [20:0] NV_T  = 21'(NV_UPDATE_CYC);
  localparam logic [20:0] CR_T  = 21'(CAL_RESTORE_CYC);
  localparam logic [20:0] BC_T  = 21'(BIAS_CORR_CYC);
  localparam logic [20:0] CK_T  = 21'(CHECKSUM_CYC);

  asc_pkg::asc_link_s l_q, l_d;
  asc_pkg::asc_core_s q, d;

  logic        frame;
  logic        busy;
  logic        done;
  logic        smp;
  logic        wr;
  logic        rd;
  logic        rd_flags;
  logic [6:0]  ra;

  function automatic logic [15:0] put(logic [15:0] old, logic [7:0] b, logic hi);
    return hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction

  // link side: shift in 16 bits, hand the word over with a toggle
  always_comb begin
    l_d = l_q;
    if (!cs_n) begin
      l_d.cnt = l_q.cnt + 4'h1;
      l_d.sh  = {l_q.sh[13:0], mosi};
      if (l_q.cnt == 4'hf) begin
        l_d.word = {l_q.sh, mosi};
        l_d.tgl  = ~l_q.tgl;
      end
    end
  end

  always_ff @(posedge sclk) begin
    if (!rst_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // answer bits change on the falling edge; tx_word is held steady during a frame
  always_ff @(negedge sclk) begin
    miso <= cs_n ? 1'b0 : q.tx_word[~l_q.cnt];
  end

  // core side decode; word is stable for many core cycles after its toggle
  assign frame    = q.tgl_s[2] ^ q.tgl_s[1];
  assign busy     = q.act != asc_pkg::ACT_IDLE;
  assign done     = busy && q.timer == 21'h0;
  assign smp      = sample_strobe && q.act != asc_pkg::ACT_RESET;
  assign ra       = {l_q.word[14:9], 1'b0};
  assign wr       = frame && l_q.word[15] && !busy;
  assign rd       = frame && !l_q.word[15];
  assign rd_flags = rd && ra == asc_pkg::OFS_FLAGS;

  always_comb begin
    logic signed [16:0] val;
    logic signed [16:0] thrx;
    logic [17:0]        cmpv;
    logic [7:0]         n;
    logic [3:0]         src;
    logic [15:0]        setf;
    logic [3:0]         lvl;
    logic               roc;
    logic               last;
    logic               hit;
    logic               pulse;
    val   = '0;
    thrx  = '0;
    cmpv  = '0;
    n     = '0;
    src   = '0;
    setf  = '0;
    roc   = 1'b0;
    last  = 1'b0;
    hit   = 1'b0;
    pulse = q.drdy_cnt != 13'h0;
    lvl   = (q.gpio[11:8] & q.gpio[3:0]) | (q.dio_s[1] & ~q.gpio[3:0]);
    d = q;
    d.tgl_s = {q.tgl_s[1:0], l_q.tgl};
    d.dio_s = {q.dio_s[0], dio_in};

    if (wr) begin
      case (ra)
        asc_pkg::OFS_THR1:   d.thr[0] = put(q.thr[0], l_q.word[7:0], l_q.word[8]);
        asc_pkg::OFS_THR2:   d.thr[1] = put(q.thr[1], l_q.word[7:0], l_q.word[8]);
        asc_pkg::OFS_WIN1:   d.win[0] = put(q.win[0], l_q.word[7:0], l_q.word[8]);
        asc_pkg::OFS_WIN2:   d.win[1] = put(q.win[1], l_q.word[7:0], l_q.word[8]);
        asc_pkg::OFS_ALMCFG: d.almcfg = put(q.almcfg, l_q.word[7:0], l_q.word[8]);
        asc_pkg::OFS_GPIO:   d.gpio   = put(q.gpio, l_q.word[7:0], l_q.word[8]) & asc_pkg::GPIO_WMASK;
        asc_pkg::OFS_MISC:   d.misc   = put(q.misc, l_q.word[7:0], l_q.word[8]) & asc_pkg::MISC_WMASK;
        asc_pkg::OFS_SLEEP:  d.sleep  = put(q.sleep, l_q.word[7:0], l_q.word[8]);
        asc_pkg::OFS_CMD:    d.cmd    = q.cmd | (put(16'h0000, l_q.word[7:0], l_q.word[8]) & asc_pkg::CMD_WMASK);
        default: ;
      endcase
    end

    if (rd) begin
      case (ra)
        asc_pkg::OFS_NVCNT:  d.tx_word = q.nvcnt;
        asc_pkg::OFS_THR1:   d.tx_word = q.thr[0];
        asc_pkg::OFS_THR2:   d.tx_word = q.thr[1];
        asc_pkg::OFS_WIN1:   d.tx_word = q.win[0];
        asc_pkg::OFS_WIN2:   d.tx_word = q.win[1];
        asc_pkg::OFS_ALMCFG: d.tx_word = q.almcfg;
        asc_pkg::OFS_GPIO:   d.tx_word = {q.gpio[15:12], lvl, q.gpio[7:0]};
        asc_pkg::OFS_MISC:   d.tx_word = q.misc;
        asc_pkg::OFS_SLEEP:  d.tx_word = q.sleep;
        asc_pkg::OFS_FLAGS:  d.tx_word = q.flags;
        asc_pkg::OFS_CMD:    d.tx_word = q.cmd;
        asc_pkg::OFS_LOTA:   d.tx_word = LOT_A;
        asc_pkg::OFS_LOTB:   d.tx_word = LOT_B;
        asc_pkg::OFS_LOTC:   d.tx_word = LOT_C;
        asc_pkg::OFS_PART:   d.tx_word = PART_ID;
        asc_pkg::OFS_SERIAL: d.tx_word = SERIAL_NO;
        default:             d.tx_word = 16'h0000;
      endcase
    end

    // two alarm monitors, evaluated on each sample
    for (int i = 0; i < 2; i++) begin
      src = q.almcfg[asc_pkg::ALM_SRC_LSB + 4 * i +: 4];
      case (src)
        asc_pkg::SRC_RATE:  val = q.almcfg[asc_pkg::ALM_FILT_BIT] ?
                                  $signed({filtered_rate_output[15], filtered_rate_output}) :
                                  $signed({coarse_rate_output[15], coarse_rate_output});
        asc_pkg::SRC_TEMP:  val = $signed({temperature_output[15], temperature_output});
        asc_pkg::SRC_FLAGS: val = $signed({1'b0, q.flags});
        default:            val = '0;
      endcase
      thrx = (src == asc_pkg::SRC_FLAGS) ? $signed({1'b0, q.thr[i]}) :
                                           $signed({q.thr[i][15], q.thr[i]});
      n    = (q.win[i][7:0] == 8'h00) ? 8'h01 : q.win[i][7:0];
      roc  = q.almcfg[asc_pkg::ALM_ROC_LSB + i];
      last = (q.wcnt[i] + 8'h01) >= n;
      cmpv = roc ? ({val[16], val} - {q.snap[i][16], q.snap[i]}) : {val[16], val};
      hit  = q.almcfg[asc_pkg::ALM_SENSE_LSB + i] ? ($signed(cmpv) > $signed({thrx[16], thrx})) :
                                                   ($signed(cmpv) < $signed({thrx[16], thrx}));
      if (smp) begin
        d.wcnt[i] = (roc && !last) ? q.wcnt[i] + 8'h01 : 8'h00;
        if (!roc || last) begin
          d.active[i] = (src != asc_pkg::SRC_OFF) && hit;
          d.snap[i]   = val;
        end
        setf[asc_pkg::FLG_ALM_LSB + i] = d.active[i];
      end
    end
    if (smp && q.sum_bad) begin
      setf[asc_pkg::FLG_SUM_BIT] = 1'b1;
    end

    // data ready pulse restarts on every sample except those taken in the cycle a soft reset starts or while it runs
    if (smp) begin
      d.drdy_cnt = asc_pkg::DRDY_CYC;
    end else if (pulse) begin
      d.drdy_cnt = q.drdy_cnt - 13'h1;
    end

    // one global function at a time, soft reset first
    if (!busy) begin
      if (q.cmd[asc_pkg::CMD_SOFT_RESET]) begin
        d.act      = asc_pkg::ACT_RESET;
        d.timer    = SR_T;
        d.act_mask = 16'h0001 << asc_pkg::CMD_SOFT_RESET;
        d.thr      = q.nv_thr;
        d.win      = q.nv_win;
        d.almcfg   = q.nv_almcfg;
        d.gpio     = q.nv_gpio;
        d.misc     = q.nv_misc;
        d.sleep    = q.nv_sleep;
        d.flags    = 16'h0000;
        d.active   = '0;
        d.snap     = '0;
        d.wcnt     = '0;
        d.drdy_cnt = 13'h0;
        setf       = 16'h0000;
      end else if (q.cmd[asc_pkg::CMD_NV_UPDATE]) begin
        d.act      = asc_pkg::ACT_NVUPD;
        d.timer    = NV_T;
        d.act_mask = 16'h0001 << asc_pkg::CMD_NV_UPDATE;
      end else if (q.cmd[asc_pkg::CMD_CAL_RESTORE]) begin
        d.act      = asc_pkg::ACT_NVUPD;
        d.timer    = CR_T;
        d.act_mask = 16'h0001 << asc_pkg::CMD_CAL_RESTORE;
      end else if (q.cmd[asc_pkg::CMD_BIAS_CORR]) begin
        d.act      = asc_pkg::ACT_NVUPD;
        d.timer    = BC_T;
        d.act_mask = 16'h0001 << asc_pkg::CMD_BIAS_CORR;
      end else if (q.misc[asc_pkg::MISC_CHECKSUM]) begin
        d.act      = asc_pkg::ACT_CHECK;
        d.timer    = CK_T;
        d.act_mask = 16'h0000;
      end
    end else if (done) begin
      d.act = asc_pkg::ACT_IDLE;
      d.cmd = q.cmd & ~q.act_mask;
      if (q.act == asc_pkg::ACT_NVUPD) begin
        d.nv_thr    = q.thr;
        d.nv_win    = q.win;
        d.nv_almcfg = q.almcfg;
        d.nv_gpio   = q.gpio;
        d.nv_misc   = q.misc;
        d.nv_sleep  = q.sleep;
        d.nvcnt     = q.nvcnt + 16'h0001;
      end
      if (q.act == asc_pkg::ACT_CHECK) begin
        d.misc[asc_pkg::MISC_CHECKSUM] = 1'b0;
        d.sum_bad = prog_sum != factory_sum;
        setf[asc_pkg::FLG_SUM_BIT] = prog_sum != factory_sum;
      end
    end else begin
      d.timer = q.timer - 21'h1;
    end
    d.halt = d.act == asc_pkg::ACT_RESET;

    // read clears, but a flag set in the same cycle survives
    d.flags = (rd_flags ? 16'h0000 : d.flags) | setf;

    // line muxing: data ready, then alarm indicator, then general use
    for (int k = 0; k < 4; k++) begin
      d.doe[k]  = q.gpio[k];
      d.dout[k] = q.gpio[asc_pkg::GPIO_DATA_LSB + k];
      if (k < 2) begin
        if (q.misc[asc_pkg::MISC_DR_EN] && q.misc[asc_pkg::MISC_DR_SEL] == k[0]) begin
          d.doe[k]  = 1'b1;
          d.dout[k] = q.misc[asc_pkg::MISC_DR_POL] ? pulse : !pulse;
        end else if (q.almcfg[asc_pkg::ALM_OUT_EN] && q.almcfg[asc_pkg::ALM_OUT_SEL] == k[0]) begin
          d.doe[k]  = 1'b1;
          d.dout[k] = q.almcfg[asc_pkg::ALM_OUT_POL] ? |q.active : !(|q.active);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q         <= '0;
      q.act     <= asc_pkg::ACT_IDLE;
      q.misc    <= asc_pkg::MISC_RST;
      q.nv_misc <= asc_pkg::MISC_RST;
    end else begin
      q <= d;
    end
  end

  assign dio_out         = q.dout;
  assign dio_oe          = q.doe;
  assign collection_halt = q.halt;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence nv_done_s;
    q.act == asc_pkg::ACT_NVUPD && q.timer == 21'h0;
  endsequence

  sequence chk_done_s;
    q.act == asc_pkg::ACT_CHECK && q.timer == 21'h0;
  endsequence

  sequence reset_start_s;
    q.act == asc_pkg::ACT_IDLE && q.cmd[asc_pkg::CMD_SOFT_RESET];
  endsequence

  cmd_self_clear_a: assert property (nv_done_s |=> q.act == asc_pkg::ACT_IDLE &&
                                     (q.cmd & $past(q.act_mask)) == 16'h0000)
    else $error("command bit not cleared at completion");

  nv_count_a: assert property (nv_done_s |=> q.nvcnt == $past(q.nvcnt) + 16'h0001 &&
                               q.nv_almcfg == $past(q.almcfg))
    else $error("write counter or stored copy not updated");

  soft_reload_a: assert property (reset_start_s |=> q.almcfg == $past(q.nv_almcfg) &&
                                  q.misc == $past(q.nv_misc) ##1 collection_halt)
    else $error("soft reset did not reload or halt collection");

  checksum_flag_a: assert property (chk_done_s |=> !q.misc[asc_pkg::MISC_CHECKSUM] &&
                                    q.sum_bad == $past(prog_sum != factory_sum) &&
                                    (!q.sum_bad || q.flags[asc_pkg::FLG_SUM_BIT]))
    else $error("checksum result not reported");

  flags_clear_a: assert property (rd_flags && !smp && !done |=> q.flags == 16'h0000)
    else $error("error flags not cleared by read");

  alarm_flag_a: assert property ($rose(q.active[1]) |-> q.flags[asc_pkg::FLG_ALM_LSB + 1])
    else $error("alarm two active without flag");

  window_one_a: assert property (smp && q.almcfg[asc_pkg::ALM_ROC_LSB] && q.win[0][7:0] <= 8'h01 &&
                                 !q.cmd[asc_pkg::CMD_SOFT_RESET] |=> q.wcnt[0] == 8'h00)
    else $error("short window not treated as one sample");

  drdy_width_a: assert property (smp && !q.cmd[asc_pkg::CMD_SOFT_RESET] |=>
                                 q.drdy_cnt >= 13'(asc_pkg::DRDY_MIN_CYC) &&
                                 q.drdy_cnt <= 13'(asc_pkg::DRDY_MAX_CYC))
    else $error("data ready pulse length out of range");

  drdy_pin_a: assert property (rst_n && q.misc[asc_pkg::MISC_DR_EN] && !q.misc[asc_pkg::MISC_DR_SEL] |=>
                               dio_oe[0] && dio_out[0] == ($past(q.misc[asc_pkg::MISC_DR_POL]) ==
                               ($past(q.drdy_cnt) != 13'h0)))
    else $error("data ready not driven on line one");

  alarm_pin_a: assert property (q.almcfg[asc_pkg::ALM_OUT_EN] && q.almcfg[asc_pkg::ALM_OUT_SEL] &&
                                !(q.misc[asc_pkg::MISC_DR_EN] && q.misc[asc_pkg::MISC_DR_SEL]) |=>
                                dio_oe[1] && dio_out[1] == ($past(q.almcfg[asc_pkg::ALM_OUT_POL]) ==
                                $past(|q.active)))
    else $error("alarm indicator level wrong on line two");

endmodule

// ===== verif/asc_host_model.sv
// host side of the serial register port: mode 3, 16-bit frames, msb first
// assumes the core shifts miso on falling sclk and samples mosi on rising sclk
`timescale 1ns/1ps
module asc_host_model (
  // serial port
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // one frame at 125 ns per bit; writing a one to a command bit starts it
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n = 1'b0;
    #62.5;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      #62.5;
      sclk = 1'b1;
      rx[i] = miso;
      #62.5;
    end
    cs_n = 1'b1;
    // released line must not keep the last bit
    mosi = ~mosi;
    #600;
  endtask
  // single edge so the link counter sees reset
  task automatic kick();
    sclk = 1'b0;
    #62.5;
    sclk = 1'b1;
  endtask
endmodule

// ===== verif/alarm_and_system_control_tb_top.sv
// self-checking bench: register access over the serial port, samples on clk
// assumes shortened command timers of 30 cycles
`timescale 1ns/1ps
module alarm_and_system_control_tb_top;
  logic        clk, rst_n, sclk, cs_n, mosi, miso, strobe, halt;
  logic [15:0] rate, psum, fsum, rd_v, filt, temp;
  logic [3:0]  dout, doe, din;
  logic [7:0]  cmds [3];
  int          error_cnt, checks, cyc;

  asc_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  asc_system_ctrl #(.SOFT_RESET_CYC(30), .NV_UPDATE_CYC(30), .CAL_RESTORE_CYC(30),
    .BIAS_CORR_CYC(30), .CHECKSUM_CYC(30)) dut (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .sample_strobe(strobe), .coarse_rate_output(rate), .filtered_rate_output(filt),
    .temperature_output(temp), .prog_sum(psum), .factory_sum(fsum), .dio_in(din),
    .dio_out(dout), .dio_oe(doe), .collection_halt(halt));

  always #20 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude();
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr8(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    host.xfer({1'b1, a, d}, r);
  endtask

  task automatic wr16(input logic [6:0] a, input logic [15:0] v);
    wr8(a, v[7:0]);
    wr8(a | 7'h01, v[15:8]);
  endtask

  task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] r;
    host.xfer({1'b0, a, 8'h00}, r);
    host.xfer(16'h0000, rd_v);
    chk(rd_v, exp);
  endtask

  task automatic smp(input logic [15:0] v);
    @(posedge clk);
    strobe <= 1'b1;
    rate   <= v;
    @(posedge clk);
    strobe <= 1'b0;
  endtask

  // counts cycles at the active level after one sample
  task automatic pulse(input logic lvl);
    int n;
    n = 0;
    smp(16'h0000);
    repeat (6000) begin
      @(negedge clk);
      if (dout[0] === lvl) n++;
    end
    chk(16'(n >= 2500 && n <= 5000), 16'h0001);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    strobe = 1'b0;
    rate = 16'h0000;
    filt = 16'h0200;
    temp = 16'h0050;
    din = 4'hc;
    psum = 16'h1111;
    fsum = 16'h1111;
    cmds = '{8'h08, 8'h02, 8'h01};
    #7;
    host.kick();
    // two clock edges pass during the kick, six in all
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk({14'h0, doe[0], dout[0]}, 16'h0002);
    rchk(asc_pkg::OFS_MISC, 16'h0006);
    rchk(asc_pkg::OFS_ALMCFG, 16'h0000);
    rchk(asc_pkg::OFS_WIN1, 16'h0000);
    rchk(asc_pkg::OFS_WIN2, 16'h0000);
    rchk(asc_pkg::OFS_CMD, 16'h0000);
    rchk(7'h3e, 16'h0000);
    pulse(1'b1);
    wr8(asc_pkg::OFS_MISC, 8'h04);
    @(negedge clk);
    chk({15'h0, dout[0]}, 16'h0001);
    pulse(1'b0);
    // soft reset drops the unsaved data ready change
    wr8(asc_pkg::OFS_CMD, 8'h80);
    repeat (6) @(negedge clk);
    chk({15'h0, halt}, 16'h0001);
    repeat (60) @(posedge clk);
    rchk(asc_pkg::OFS_MISC, 16'h0006);
    rchk(asc_pkg::OFS_CMD, 16'h0000);
    // alarm 1: coarse rate above threshold, indicator high on line two
    wr16(asc_pkg::OFS_THR1, 16'h0100);
    wr16(asc_pkg::OFS_ALMCFG, 16'h0117);
    smp(16'h0200);
    repeat (4) @(negedge clk);
    chk({14'h0, doe[1], dout[1]}, 16'h0003);
    rchk(asc_pkg::OFS_FLAGS, 16'h0100);
    smp(16'h0050);
    repeat (4) @(negedge clk);
    chk({14'h0, doe[1], dout[1]}, 16'h0002);
    rchk(asc_pkg::OFS_FLAGS, 16'h0000);
    // rate of change: alarm 1 on temperature over one sample, alarm 2 on rate over two
    wr16(asc_pkg::OFS_THR2, 16'h0100);
    wr16(asc_pkg::OFS_WIN2, 16'hff02);
    wr16(asc_pkg::OFS_ALMCFG, 16'h12f0);
    smp(16'h0200);
    rchk(asc_pkg::OFS_FLAGS, 16'h0000);
    @(posedge clk);
    temp <= 16'h0200;
    smp(16'h0200);
    rchk(asc_pkg::OFS_FLAGS, 16'h0300);
    // filtered rate above on alarm 1, flags below on alarm 2; data ready outranks the indicator on line one
    wr16(asc_pkg::OFS_ALMCFG, 16'h311c);
    smp(16'h0000);
    repeat (4) @(negedge clk);
    chk({14'h0, doe[0], dout[0]}, 16'h0003);
    rchk(asc_pkg::OFS_FLAGS, 16'h0300);
    wr8(asc_pkg::OFS_MISC, 8'h02);
    @(negedge clk);
    chk({14'h0, doe[0], dout[0]}, 16'h0002);
    wr8(asc_pkg::OFS_MISC, 8'h06);
    // lines three and four under general control, input levels read back
    wr16(asc_pkg::OFS_GPIO, 16'h0808);
    rchk(asc_pkg::OFS_GPIO, 16'h0c08);
    chk({12'h0, doe[3:2], dout[3:2]}, 16'h000a);
    // each commit command counts once
    for (int i = 0; i < 3; i++) begin
      wr8(asc_pkg::OFS_CMD, cmds[i]);
      repeat (60) @(posedge clk);
    end
    rchk(asc_pkg::OFS_NVCNT, 16'h0003);
    rchk(asc_pkg::OFS_CMD, 16'h0000);
    @(posedge clk);
    fsum <= 16'h2222;
    wr8(7'h1d, 8'h08);
    repeat (60) @(posedge clk);
    rchk(asc_pkg::OFS_FLAGS, 16'h0040);
    rchk(asc_pkg::OFS_MISC, 16'h0006);
    conclude();
  end
endmodule
